// [hdl/bpci_pkg.sv]
package bpci_pkg;
    // Port geometry
    localparam int PORT_WIDTH      = 8;           // Pins in the port
    localparam int CHG_LO          = 4;           // Lowest change-detect pin
    localparam int CHG_HI          = 7;           // Highest change-detect pin
    localparam int EXT_INT_BIT     = 0;           // External interrupt pin
    // Field positions
    localparam int OPT_PULLUP_N_BIT = 7;          // Option reg: pull-up enable, active low
    localparam int OPT_EDGE_BIT     = 6;          // Option reg: external edge select
    localparam int ICR_CHG_FLAG_BIT = 0;          // Interrupt control: change flag
    // Reset values
    localparam logic [7:0] DIR_RST  = 8'hFF;      // All pins input
    localparam logic [7:0] LAT_RST  = 8'h00;      // Output latches
    localparam logic       PULLUP_N_RST = 1'b1;   // Pull-ups off after power-on

    // Peripheral direction override for one pin set
    typedef struct packed {
        logic [7:0] force_en;                     // Override active per pin
        logic [7:0] force_in;                     // 1 = force input, 0 = force output
    } bpci_ovr_t;

    // Software access strobes to the data port
    typedef struct packed {
        logic       rd;                           // Port read
        logic       wr;                           // Port write
        logic [7:0] wdata;                        // Write data
    } bpci_acc_t;
endpackage

// [hdl/bpci_chg_det.sv]
`timescale 1ns/100ps
`default_nettype none
// Change detector on the upper nibble
module bpci_chg_det
    import bpci_pkg::*;
(
    input  wire logic       sys_clk_i,    // System clock
    input  wire logic       rst_i,        // Async reset
    input  wire logic [3:0] pins_i,       // Synchronised upper pins
    input  wire logic [3:0] is_input_i,   // Effective input mask
    input  wire logic       refresh_i,    // Port read or write
    output logic            mismatch_o    // Any participating pin differs
);
    logic [3:0] old_r;                    // Value latched at last access
    wire  [3:0] diff_w = (pins_i ^ old_r) & is_input_i;

    assign mismatch_o = |diff_w;

    // Re-latch on each access, ending the mismatch
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            old_r <= 4'h0;
        end else if (refresh_i) begin
            old_r <= pins_i;
        end
    end
endmodule
`default_nettype wire

// [hdl/bpci_edge_det.sv]
`timescale 1ns/100ps
`default_nettype none
// Selectable edge detector for the external interrupt pin
module bpci_edge_det
(
    input  wire logic sys_clk_i,   // System clock
    input  wire logic rst_i,       // Async reset
    input  wire logic pin_i,       // Synchronised pin level
    input  wire logic rising_i,    // 1 = rising edge, 0 = falling
    output logic      edge_o       // One-cycle pulse on chosen edge
);
    logic prev_r;                  // Last level seen
    logic primed_r;                // Low until one level has been captured after reset
    // Without priming, a pin resting high at release would look like a rising edge
    wire  rise_w = primed_r & pin_i & ~prev_r;
    wire  fall_w = primed_r & ~pin_i & prev_r;

    assign edge_o = rising_i ? rise_w : fall_w;

    // Remember previous level
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_r   <= 1'b0;
            primed_r <= 1'b0;
        end else begin
            prev_r   <= pin_i;
            primed_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [hdl/bpci_port.sv]
`timescale 1ns/100ps
`default_nettype none
// Behaviour notes
// All strobes are one-cycle pulses taken at the rising clock edge.
// Register updates show on the outputs in the following cycle.
// Direction bit 1 means input; the drive enable is low while driving.
// Peripheral overrides win over the direction bit for as long as they stand.
// Pull-ups follow the effective direction, so an override also moves them.
// The compare latch resets to zero: inputs held high through reset
// will raise the change flag until software first touches the port.
// That is deliberate, it mirrors a part that has never been read.
// Every read re-latches the compare values; a change that lands in the
// read cycle still sets the flag, since the compare sees it first.
// The change flag is set and cleared in one process; when a new
// mismatch and a clear pulse meet in one cycle, the set wins.
// Clearing the flag only sticks once an access has ended the mismatch.
// The external interrupt flag behaves the same way for its edge events.
// The edge select resets to rising.
// Wake needs the change enable for the change flag, none for the external flag; the global enable is not used,
// because a sleeping part must wake even with interrupts masked.
// Flags never look at either enable, so software should clear stale
// flags before it enables a source.
// Read data is the raw pin level captured at the read strobe; pins are
// taken as already synchronous to the system clock.
// Limitation: the logic is sized for eight pins and one change nibble.
//
module bpci_port
    import bpci_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH     // Port width
)
(
    input  wire logic             sys_clk_i,        // System clock
    input  wire logic             rst_i,            // Async reset, active high
    // Software access
    input  wire bpci_acc_t        port_acc_i,       // Data port strobes
    output logic [WIDTH-1:0]      port_rdata_o,     // Port read data
    input  wire logic             dir_wr_i,         // Direction reg write
    input  wire logic [WIDTH-1:0] dir_wdata_i,      // Direction write data
    output logic [WIDTH-1:0]      pin_direction_reg_o, // Direction readback
    input  wire logic             opt_wr_i,         // Option bits write
    input  wire logic [7:0]       opt_wdata_i,      // Option write data
    output logic                  pullup_enable_n_o,    // Pull-up control readback
    output logic                  ext_int_edge_select_o,// Edge select readback
    input  wire logic             global_irq_enable_i,  // Global enable, not used
    input  wire logic             chg_ie_i,         // Change interrupt enable
    input  wire logic             chg_flag_clr_i,   // Software clears change flag
    output logic                  port_change_flag_o, // Change flag
    input  wire logic             ext_flag_clr_i,   // Software clears external flag
    output logic                  ext_int_flag_o,   // External interrupt flag
    input  wire logic             sleep_i,          // Device is asleep
    output logic                  wake_o,           // Wake request
    // Peripheral overrides
    input  wire bpci_ovr_t        ovr_i,            // Direction overrides
    // Pins
    input  wire logic [WIDTH-1:0] pin_i,            // Pin levels
    output logic [WIDTH-1:0]      pin_o,            // Pin drive value
    output logic [WIDTH-1:0]      pin_oe_n_o,       // Low while driving
    output logic [WIDTH-1:0]      pullup_on_o       // Weak pull-up enable per pin
);
    // Elaboration check: logic is sized for eight pins
    if (WIDTH != PORT_WIDTH) begin : g_bad_width
        $error("bpci_port supports WIDTH of 8 only");
    end
    // Elaboration check: change nibble must be four pins inside the port
    if (CHG_HI >= WIDTH || CHG_LO > CHG_HI || CHG_HI - CHG_LO != 3) begin : g_bad_nibble
        $error("bpci_port change-detect range does not fit the port");
    end
    // Elaboration check: external interrupt pin must exist
    if (EXT_INT_BIT >= WIDTH) begin : g_bad_ext
        $error("bpci_port external interrupt pin outside the port");
    end

    logic [WIDTH-1:0] lat_r;              // Output latches
    logic [WIDTH-1:0] dir_r;              // Direction register, 1 = input
    logic             pullup_n_r;         // Pull-up control, active low
    logic             edge_r;             // External edge select
    logic             chg_flag_r;         // Change flag
    logic             ext_flag_r;         // External interrupt flag
    logic [WIDTH-1:0] rdata_r;            // Registered read data
    logic             mismatch_w;         // Any change mismatch
    logic             ext_edge_w;         // Selected edge on lowest pin

    // Effective direction after peripheral override
    wire [WIDTH-1:0] eff_in_w = (dir_r & ~ovr_i.force_en)
                              | (ovr_i.force_in & ovr_i.force_en);
    // Port access refresh strobe
    wire             access_w = port_acc_i.rd | port_acc_i.wr;
    wire             chg_nxt  = mismatch_w | (chg_flag_r & ~chg_flag_clr_i);
    wire             ext_nxt  = ext_edge_w | (ext_flag_r & ~ext_flag_clr_i);

    // Pin drive: latch value, enable low on outputs
    assign pin_o       = lat_r;
    assign pin_oe_n_o  = eff_in_w;
    // Pull-ups only on inputs with control cleared
    assign pullup_on_o = eff_in_w & {WIDTH{~pullup_n_r}};

    assign port_rdata_o          = rdata_r;
    assign pin_direction_reg_o   = dir_r;
    assign pullup_enable_n_o     = pullup_n_r;
    assign ext_int_edge_select_o = edge_r;
    assign port_change_flag_o    = chg_flag_r;
    assign ext_int_flag_o        = ext_flag_r;
    // Change wake needs only its enable, external wake none; no global enable
    assign wake_o = sleep_i & ((chg_flag_r & chg_ie_i) | ext_flag_r);

    // Upper nibble comparison; polling re-latches it
    bpci_chg_det u_chg (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .pins_i     (pin_i[CHG_HI:CHG_LO]),
        .is_input_i (eff_in_w[CHG_HI:CHG_LO]),
        .refresh_i  (access_w),
        .mismatch_o (mismatch_w)
    );

    // External interrupt edge on lowest pin
    bpci_edge_det u_edge (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pin_i     (pin_i[EXT_INT_BIT]),
        .rising_i  (edge_r),
        .edge_o    (ext_edge_w)
    );

    // Output latches and read data
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lat_r   <= LAT_RST;
            rdata_r <= LAT_RST;
        end else begin
            if (port_acc_i.wr) begin
                lat_r <= port_acc_i.wdata;
            end
            if (port_acc_i.rd) begin
                rdata_r <= pin_i;
            end
        end
    end

    // Direction and option bits
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dir_r      <= DIR_RST;
            pullup_n_r <= PULLUP_N_RST;
            edge_r     <= 1'b1;
        end else begin
            if (dir_wr_i) begin
                dir_r <= dir_wdata_i;
            end
            if (opt_wr_i) begin
                pullup_n_r <= opt_wdata_i[OPT_PULLUP_N_BIT];
                edge_r     <= opt_wdata_i[OPT_EDGE_BIT];
            end
        end
    end

    // Flags: set wins over clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            chg_flag_r <= 1'b0;
            ext_flag_r <= 1'b0;
        end else begin
            chg_flag_r <= chg_nxt;
            ext_flag_r <= ext_nxt;
        end
    end

    // Checks
    // No output pin may ever carry a pull-up
    a_pullup_off_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (pullup_on_o & ~pin_oe_n_o) == '0) else $error("pull-up on output pin");

    // Control set means every pull-up is off
    a_pullup_ctrl: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        pullup_n_r |-> pullup_on_o == '0) else $error("pull-up with control set");

    // Control cleared turns on the pull-up of every input pin
    a_pullup_on_in: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !pullup_n_r |-> pullup_on_o == pin_oe_n_o) else $error("pull-up missing on input");

    // Any mismatch sets the flag one cycle later
    a_chg_sets: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        mismatch_w |=> chg_flag_r) else $error("mismatch did not set flag");

    // No mismatch and no flag means the flag stays low
    a_chg_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!mismatch_w && !chg_flag_r) |=> !chg_flag_r) else $error("flag set without mismatch");

    // The flag stands until a clear pulse
    a_chg_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (chg_flag_r && !chg_flag_clr_i) |=> chg_flag_r) else $error("flag lost");

    // A clear with the mismatch ended does clear the flag
    a_chg_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (chg_flag_clr_i && !mismatch_w) |=> !chg_flag_r) else $error("flag not cleared");

    // An access with quiet pins ends the mismatch
    a_refresh_ends: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (access_w && $stable(pin_i) && $stable(eff_in_w)) ##1 ($stable(pin_i) && $stable(eff_in_w))
        |-> !mismatch_w) else $error("access did not end mismatch");

    // Output pins never take part in the comparison
    a_no_chg_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (eff_in_w[CHG_HI:CHG_LO] == 4'h0) |-> !mismatch_w) else $error("output pin compared");

    // A port write lands in the output latches, inputs included
    a_drive_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        port_acc_i.wr |=> pin_o == $past(port_acc_i.wdata)) else $error("latch not written");

    // A port read returns the pin levels of the strobe cycle
    a_read_pins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        port_acc_i.rd |=> port_rdata_o == $past(pin_i)) else $error("read data wrong");

    // Direction writes land whole
    a_dir_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        dir_wr_i |=> pin_direction_reg_o == $past(dir_wdata_i)) else $error("direction not written");

    // Without override the direction bit alone sets the drive enable
    a_dir_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ((pin_oe_n_o ^ pin_direction_reg_o) & ~ovr_i.force_en) == '0)
        else $error("drive enable differs from direction");

    // Overrides win over the direction bit
    a_override_dir: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (pin_oe_n_o & ovr_i.force_en) == (ovr_i.force_in & ovr_i.force_en))
        else $error("override ignored");

    // Option writes land in both control bits
    a_opt_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        opt_wr_i |=> (pullup_enable_n_o == $past(opt_wdata_i[OPT_PULLUP_N_BIT]))
        && (ext_int_edge_select_o == $past(opt_wdata_i[OPT_EDGE_BIT]))) else $error("option not written");

    // Enabled change flag wakes a sleeping part
    a_wake: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (sleep_i && chg_flag_r && chg_ie_i) |-> wake_o) else $error("no wake");

    // No wake while awake
    a_wake_awake: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !sleep_i |-> !wake_o) else $error("wake while awake");

    // Rising edge caught when selected; first cycle after reset is priming
    a_ext_edge: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (edge_r && $rose(pin_i[EXT_INT_BIT]) && $stable(edge_r) && !$past(rst_i)) |=> ext_flag_r)
        else $error("edge missed");

    // Falling edge caught when selected
    a_ext_fall: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!edge_r && $fell(pin_i[EXT_INT_BIT]) && $stable(edge_r) && !$past(rst_i)) |=> ext_flag_r)
        else $error("falling edge missed");

    // Main scenarios
    c_change_flag: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(chg_flag_r));
    c_flag_clear:  cover property (@(posedge sys_clk_i) disable iff (rst_i) $fell(chg_flag_r));
    c_ext_edge:    cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(ext_flag_r));
    c_wake:        cover property (@(posedge sys_clk_i) disable iff (rst_i) wake_o);
    // Clear refused by a standing mismatch
    c_persist:     cover property (@(posedge sys_clk_i) disable iff (rst_i) chg_flag_clr_i && mismatch_w);
endmodule
`default_nettype wire

// [bench/bpci_pins_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Far-side circuits on the pins: external drivers, pull-ups, floating lines
module bpci_pins_model
(
    input  wire logic       sys_clk_i,  // System clock
    input  wire logic [7:0] pin_o_i,    // Design drive value
    input  wire logic [7:0] oe_n_i,     // Design enable, low while driving
    input  wire logic [7:0] pullup_i,   // Weak pull-up per pin
    input  wire logic [7:0] ext_en_i,   // External driver active
    input  wire logic [7:0] ext_val_i,  // External driver value
    output logic [7:0]      level_o     // Resolved wire level
);
    logic [7:0] float_r = 8'h55;        // Toggles so a floating line never looks stable
    // Floating pattern changes every cycle
    always_ff @(posedge sys_clk_i) begin
        float_r <= ~float_r;
    end
    // Resolution order: design driver, external driver, pull-up, float
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!oe_n_i[i]) level_o[i] = pin_o_i[i];
            else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
            else if (pullup_i[i]) level_o[i] = 1'b1;
            else level_o[i] = float_r[i];
        end
    end
endmodule
`default_nettype wire

// [bench/test_bidir_port_with_change_irq.sv]
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the port
module test_bidir_port_with_change_irq;
    import bpci_pkg::*;
    logic       sys_clk_i, rst_i, dir_wr, opt_wr, pu_n, edg, global_irq_enable, ie, cclr, eclr, cflag, eflag, sleep, wake;
    logic [7:0] rdata, dir_wd, dir_q, opt_wd, pin_q, oe_n, pu, lvl, ext_en, ext_val;
    bpci_acc_t  acc;  // Port strobes
    bpci_ovr_t  ovr;  // Peripheral overrides
    int         n_fail, tests_run;
    bpci_port uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .port_acc_i(acc), .port_rdata_o(rdata),
        .dir_wr_i(dir_wr), .dir_wdata_i(dir_wd), .pin_direction_reg_o(dir_q), .opt_wr_i(opt_wr),
        .opt_wdata_i(opt_wd), .pullup_enable_n_o(pu_n), .ext_int_edge_select_o(edg),
        .global_irq_enable_i(global_irq_enable), .chg_ie_i(ie), .chg_flag_clr_i(cclr), .port_change_flag_o(cflag),
        .ext_flag_clr_i(eclr), .ext_int_flag_o(eflag), .sleep_i(sleep), .wake_o(wake), .ovr_i(ovr),
        .pin_i(lvl), .pin_o(pin_q), .pin_oe_n_o(oe_n), .pullup_on_o(pu));
    bpci_pins_model pins (.sys_clk_i(sys_clk_i), .pin_o_i(pin_q), .oe_n_i(oe_n), .pullup_i(pu),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));
    // Clock, 100 ns period
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // Compare and count
    task check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Verdict and end of run
    task end_sim;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // One-cycle strobes, all launched at the falling edge
    task port(input logic rd, input logic wr, input logic [7:0] d);
        acc = '{rd: rd, wr: wr, wdata: d}; cyc(1); acc = '0; cyc(1);
    endtask
    task wdir(input logic [7:0] d);
        dir_wd = d; dir_wr = 1'b1; cyc(1); dir_wr = 1'b0; cyc(1);
    endtask
    task wopt(input logic [7:0] d);
        opt_wd = d; opt_wr = 1'b1; cyc(1); opt_wr = 1'b0; cyc(1);
    endtask
    task clr(input bit ext);
        if (ext) eclr = 1'b1; else cclr = 1'b1;
        cyc(1); eclr = 1'b0; cclr = 1'b0; cyc(1);
    endtask
    // Bounded wait for a flag level; running out ends the run
    task wait_flag(input bit ext, input logic exp);
        int k;
        for (k = 0; k < 8 && (ext ? eflag : cflag) !== exp; k++) cyc(1);
        if (k == 8) begin
            n_fail++;
            $display("mismatch flag wait expected %b seen %b", exp, ext ? eflag : cflag);
            end_sim();
        end
        tests_run++;
    endtask
    // Values straight after reset
    task t_reset;
        check("dir", DIR_RST, dir_q);
        check("oe_n", 8'hFF, oe_n);
        check("pullups", 8'h00, {pu[7:1], pu_n ^ 1'b1});
        check("latch", LAT_RST, pin_q);
    endtask
    // Latch written while input, then driven; pull-ups and overrides
    task t_drive;
        ext_val = 8'h3C;
        port(1'b0, 1'b1, 8'hA5);
        check("latch", 8'hA5, pin_q);
        check("oe_n in", 8'hFF, oe_n);
        wdir(8'h0F); cyc(3);
        check("oe_n out", 8'h0F, oe_n);
        port(1'b1, 1'b0, 8'h00);
        check("rdata", 8'hAC, rdata);
        wopt(8'h40);
        check("pullup on", 8'h0F, pu);
        wopt(8'hC0);
        check("pullup off", 8'h00, pu);
        ovr = '{force_en: 8'h12, force_in: 8'h10}; cyc(1);
        check("override", 8'h1D, oe_n);
        ovr = '0; wdir(8'hFF);
    endtask
    // Change detection on the upper nibble, flag, wake and refresh
    task t_change;
        ext_val = 8'h00; cyc(4); port(1'b1, 1'b0, 8'h00); cyc(3); clr(1'b0);
        check("flag idle", 8'h00, {7'h00, cflag});
        ext_val = 8'h08; cyc(6);
        check("low pin", 8'h00, {7'h00, cflag});
        ext_val = 8'h88;
        wait_flag(1'b0, 1'b1);
        sleep = 1'b1; ie = 1'b1; cyc(1);
        check("wake", 8'h01, {7'h00, wake});
        sleep = 1'b0; clr(1'b0);
        check("persist", 8'h01, {7'h00, cflag});
        port(1'b1, 1'b0, 8'h00); cyc(2); clr(1'b0);
        check("read clr", 8'h00, {7'h00, cflag});
        ext_val = 8'h98;
        wait_flag(1'b0, 1'b1);
        port(1'b0, 1'b1, 8'h00); cyc(2); clr(1'b0);
        check("write clr", 8'h00, {7'h00, cflag});
    endtask
    // External interrupt pin, both edge selections
    task t_ext;
        clr(1'b1); ext_val[0] = 1'b1;
        wait_flag(1'b1, 1'b1);
        wopt(8'h80); clr(1'b1);
        check("edge sel", 8'h00, {7'h00, edg});
        ext_val[0] = 1'b0;
        wait_flag(1'b1, 1'b1);
        clr(1'b1); ext_val[0] = 1'b1; cyc(6);
        check("wrong edge", 8'h00, {7'h00, eflag});
    endtask
    // Main sequence
    initial begin
        n_fail = 0; tests_run = 0; rst_i = 1'b1; acc = '0; ovr = '0;
        dir_wr = 1'b0; opt_wr = 1'b0; dir_wd = 8'h00; opt_wd = 8'h00;
        global_irq_enable = 1'b0; ie = 1'b0; cclr = 1'b0; eclr = 1'b0; sleep = 1'b0;
        ext_en = 8'hFF; ext_val = 8'h00;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i) rst_i = 1'b0;
        t_reset();
        t_drive();
        t_change();
        t_ext();
        end_sim();
    end
endmodule
`default_nettype wire
